//--- common/odt_ctrl_map.svh
`ifndef ODT_CTRL_MAP_SVH
`define ODT_CTRL_MAP_SVH

// command encoding on {csN, rasN, casN, weN}
`define CMD_WRITE 4'h4
`define CMD_MRS 4'h0
`define CMD_REFRESH 4'h1

// mode register select on the bank address
`define MR0_SEL 3'h0
`define MR1_SEL 3'h1
`define MR2_SEL 3'h2

// field positions inside the mode register and write command address words
`define MR0_DLL_PD_BIT 12
`define MR0_BL_HI 1
`define MR0_BL_LO 0
`define MR1_NOM_B2 9
`define MR1_NOM_B1 6
`define MR1_NOM_B0 2
`define MR2_WR_HI 10
`define MR2_WR_LO 9
`define WR_OTF_BIT 12

// burst length field values
`define BL_FIXED8 2'h0
`define BL_OTF 2'h1
`define BL_FIXED4 2'h2

// latencies in link clock cycles
`define ODTL_OFFSET 5'h02
`define CWN_BC4 6'h04
`define CWN_BL8 6'h06
`define CPDED_CK 8'h01
`define RFC_CK 8'h08

// reset values and odt history depth
`define MR_RESET 16'h0000
`define ODT_HIST_DEPTH 32

`endif

//--- common/odt_ctrl_pkg.sv
package odt_ctrl_pkg;

	typedef enum logic [2:0]
	{
		MODE_SYNC = 3'b001,
		MODE_TRANS = 3'b010,
		MODE_ASYNC = 3'b100
	} odtMode_e;

	typedef logic [2:0] rttCode_t;

endpackage

//--- hdl/odt_delay_line.sv
`timescale 1ns/1ps
module odt_delay_line #(
	parameter int DEPTH = 32
) (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic shiftEn, // one link clock edge seen
	input wire logic din, // level registered at that edge
	input wire logic [4:0] tapSel, // latency in link cycles
	output logic dout // level registered tapSel edges ago
);
	logic [DEPTH-1:0] hist_r;

	// tap 0 is the level registered at the most recent link edge
	always_ff @(posedge clk)
	begin
		if (reset)
			hist_r <= '0;
		else if (shiftEn)
			hist_r <= {hist_r[DEPTH-2:0], din};
	end

	assign dout = hist_r[tapSel];
endmodule // odt_delay_line

//--- hdl/dram_odt_ctrl.sv
`timescale 1ns/1ps
`include "odt_ctrl_map.svh"
// Function
// - dynamic termination enabled when either MR2 A9 or A10 is one.
// - nominal strength comes from MR1 bits A9, A6, A2.
// - write strength comes from MR2 bits A10, A9.
// - without a write in progress, nominal strength applies when termination is on.
// - termination on/off follows registered ODT after WL-2 link cycles.
// - with dynamic enabled, write strength selected WL-2 cycles after a write.
// - nominal strength returns 4 or 6 plus ODTLoff cycles after write.
// - strength change lands half a link cycle after its latency point.
// - asynchronous timing in precharge power-down when MR0 A12 freezes DLL.
// - asynchronous termination is not delayed by additive latency.
// - asynchronous turn-on/off follows sampled ODT without cycle latencies.
// - power-down entry transition period only when MR0 A12 is zero.
// - transition runs from after tANPD start to end of tCPDED(min).
// - refresh in progress extends transition to later of tRFC end.
// - during transition, termination may follow either timing.
module dram_odt_ctrl (
	input wire logic sys_clk, // system clock, 10 MHz
	input wire logic reset, // synchronous, active high
	input wire logic ckPin, // link clock from controller
	input wire logic odtPin, // termination request pin
	input wire logic ckePin, // clock enable pin
	input wire logic csN, // chip select, active low
	input wire logic rasN, // row strobe, active low
	input wire logic casN, // column strobe, active low
	input wire logic weN, // write enable, active low
	input wire logic [2:0] bankAddr, // bank / mode register select
	input wire logic [15:0] addrPin, // address bus
	input wire logic [4:0] writeLatency, // WL in link cycles, 5 or more
	input wire logic allBanksIdle, // all banks precharged
	output logic termOn, // termination switched on
	output odt_ctrl_pkg::rttCode_t rttCode, // strength applied
	output logic rttWrSel, // write strength selected
	output logic dynEnable, // dynamic switching enabled
	output logic asyncMode, // asynchronous timing in force
	output logic transition // power-down entry transition
);
	localparam int PIN_W = 26;

	logic [PIN_W-1:0] rawPins;
	logic [PIN_W-1:0] pinMeta_r;
	logic [PIN_W-1:0] pinSync_r;
	logic ckPrev_r;
	logic ckeReg_r;
	logic [15:0] mr0_r;
	logic [15:0] mr1_r;
	logic [15:0] mr2_r;
	logic wrActive_r;
	logic wrPend_r;
	logic [5:0] wrCnt_r;
	logic [5:0] wrEnd_r;
	logic [7:0] refCnt_r;
	logic [7:0] tranCnt_r;
	odt_ctrl_pkg::odtMode_e mode_r;
	odt_ctrl_pkg::odtMode_e mode_nxt;
	logic termOn_r;
	odt_ctrl_pkg::rttCode_t rttCode_r;
	logic rttWrSel_r;
	logic dynEnable_r;
	logic asyncMode_r;
	logic transition_r;

	assign rawPins = {ckPin, odtPin, ckePin, csN, rasN, casN, weN, bankAddr, addrPin};

	// whole pin group crosses together; the controller keeps it stable around CK
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
			ckPrev_r <= 1'b0;
		end
		else
		begin
			pinMeta_r <= rawPins;
			pinSync_r <= pinMeta_r;
			ckPrev_r <= pinSync_r[25];
		end
	end

	wire ckS = pinSync_r[25];
	wire odtS = pinSync_r[24];
	wire ckeS = pinSync_r[23];
	wire [3:0] cmdS = pinSync_r[22:19];
	wire [2:0] bankS = pinSync_r[18:16];
	wire [15:0] addrS = pinSync_r[15:0];
	wire ckRise = ckS & ~ckPrev_r;
	wire ckFall = ~ckS & ckPrev_r;
	wire cmdValid = ckRise & ckeS & ckeReg_r;
	wire isWrite = cmdValid & (cmdS == `CMD_WRITE);
	wire isMrs = cmdValid & (cmdS == `CMD_MRS);
	wire isRef = cmdValid & (cmdS == `CMD_REFRESH);

	wire [2:0] rttNom = {mr1_r[`MR1_NOM_B2], mr1_r[`MR1_NOM_B1], mr1_r[`MR1_NOM_B0]};
	wire [1:0] rttWr = mr2_r[`MR2_WR_HI:`MR2_WR_LO];
	wire dynEn = |rttWr;
	wire odtEn = (|rttNom) | (|rttWr);
	wire dllFrozen = ~mr0_r[`MR0_DLL_PD_BIT];
	wire [1:0] blMode = mr0_r[`MR0_BL_HI:`MR0_BL_LO];
	wire chop = (blMode == `BL_FIXED4) | ((blMode == `BL_OTF) & ~addrS[`WR_OTF_BIT]);
	wire [4:0] odtl = writeLatency - `ODTL_OFFSET;
	wire [5:0] odtlExt = {1'b0, odtl};
	wire [5:0] wrCntInc = wrCnt_r + 6'h01;
	wire [5:0] wrEndNew = odtlExt + (chop ? `CWN_BC4 : `CWN_BL8);
	wire pdEntry = ckRise & ckeReg_r & ~ckeS & dllFrozen & allBanksIdle;
	wire [7:0] tranLen = (refCnt_r > `CPDED_CK) ? refCnt_r : `CPDED_CK;
	wire odtDelayed;
	wire [2:0] codeNext = wrPend_r ? {1'b0, rttWr} : rttNom;

	odt_delay_line #(
		.DEPTH(`ODT_HIST_DEPTH)
	) u_hist (
		.clk(sys_clk),
		.reset(reset),
		.shiftEn(ckRise),
		.din(odtS),
		.tapSel(odtl),
		.dout(odtDelayed)
	);

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			ckeReg_r <= 1'b0;
		else if (ckRise)
			ckeReg_r <= ckeS;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			mr0_r <= `MR_RESET;
			mr1_r <= `MR_RESET;
			mr2_r <= `MR_RESET;
		end
		else if (isMrs)
		begin
			if (bankS == `MR0_SEL)
				mr0_r <= addrS;
			if (bankS == `MR1_SEL)
				mr1_r <= addrS;
			if (bankS == `MR2_SEL)
				mr2_r <= addrS;
		end
	end

	// write strength window; a new write restarts the count so the window stretches
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wrActive_r <= 1'b0;
			wrPend_r <= 1'b0;
			wrCnt_r <= 6'h00;
			wrEnd_r <= 6'h00;
		end
		else if (!dynEn)
		begin
			wrActive_r <= 1'b0;
			wrPend_r <= 1'b0;
		end
		else if (isWrite)
		begin
			wrActive_r <= 1'b1;
			wrCnt_r <= 6'h00;
			wrEnd_r <= wrEndNew;
		end
		else if (ckRise && wrActive_r)
		begin
			wrCnt_r <= wrCntInc;
			if (wrCntInc == odtlExt)
				wrPend_r <= 1'b1;
			if (wrCntInc == wrEnd_r)
			begin
				wrPend_r <= 1'b0;
				wrActive_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			refCnt_r <= 8'h00;
		else if (isRef)
			refCnt_r <= `RFC_CK;
		else if (ckRise && refCnt_r != 8'h00)
			refCnt_r <= refCnt_r - 8'h01;
	end

	always_comb
	begin
		mode_nxt = mode_r;
		unique case (mode_r)
			odt_ctrl_pkg::MODE_SYNC:
				if (pdEntry)
					mode_nxt = odt_ctrl_pkg::MODE_TRANS;
			odt_ctrl_pkg::MODE_TRANS:
				if (ckRise && ckeS)
					mode_nxt = odt_ctrl_pkg::MODE_SYNC;
				else if (ckRise && tranCnt_r == 8'h01)
					mode_nxt = odt_ctrl_pkg::MODE_ASYNC;
			odt_ctrl_pkg::MODE_ASYNC:
				if (ckRise && ckeS)
					mode_nxt = odt_ctrl_pkg::MODE_SYNC;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			mode_r <= odt_ctrl_pkg::MODE_SYNC;
			tranCnt_r <= 8'h00;
		end
		else
		begin
			mode_r <= mode_nxt;
			if (pdEntry && mode_r == odt_ctrl_pkg::MODE_SYNC)
				tranCnt_r <= tranLen;
			else if (ckRise && tranCnt_r != 8'h00)
				tranCnt_r <= tranCnt_r - 8'h01;
		end
	end

	// the sync path lands on the falling link edge: half a cycle past the latency point
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			termOn_r <= 1'b0;
			rttCode_r <= 3'h0;
			rttWrSel_r <= 1'b0;
		end
		else
		begin
			if (mode_r == odt_ctrl_pkg::MODE_SYNC)
			begin
				if (ckFall)
					termOn_r <= odtDelayed & odtEn;
			end
			else
				termOn_r <= odtS & odtEn;
			if (ckFall)
			begin
				rttWrSel_r <= wrPend_r;
				rttCode_r <= codeNext;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			dynEnable_r <= 1'b0;
			asyncMode_r <= 1'b0;
			transition_r <= 1'b0;
		end
		else
		begin
			dynEnable_r <= dynEn;
			asyncMode_r <= (mode_r == odt_ctrl_pkg::MODE_ASYNC);
			transition_r <= (mode_r == odt_ctrl_pkg::MODE_TRANS);
		end
	end

	assign termOn = termOn_r;
	assign rttCode = rttCode_r;
	assign rttWrSel = rttWrSel_r;
	assign dynEnable = dynEnable_r;
	assign asyncMode = asyncMode_r;
	assign transition = transition_r;
endmodule // dram_odt_ctrl

//--- bench/dram_odt_ctrl_sva.sv
`timescale 1ns/1ps
module dram_odt_ctrl_sva (
	input wire logic sys_clk, // clock
	input wire logic reset, // reset
	input wire logic odtPin, // odt
	input wire logic ckePin, // cke
	input wire logic allBanksIdle, // idle
	input wire logic termOn, // on
	input wire odt_ctrl_pkg::rttCode_t rttCode, // strength
	input wire logic rttWrSel, // write sel
	input wire logic dynEnable, // dynamic
	input wire logic asyncMode, // async
	input wire logic transition // pd entry
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// sys_clk cycles since odtPin was last seen high, saturating
	logic [8:0] odtAge;
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			odtAge <= 9'h1FF;
		else if (odtPin)
			odtAge <= 9'h000;
		else if (odtAge != 9'h1FF)
			odtAge <= odtAge + 9'h001;
	end
	sequence odtUp;
		asyncMode && $rose(odtPin) && rttCode != 3'h0;
	endsequence
	sequence odtDown;
		asyncMode && $fell(odtPin);
	endsequence
	AST_ASY_ON: assert property (odtUp ##1 (asyncMode && odtPin)[*3] |-> termOn)
		else $error("async turn-on late");
	AST_ASY_OFF: assert property (odtDown ##1 (asyncMode && !odtPin)[*3] |-> !termOn)
		else $error("async turn-off late");
	// pin to output is two sync flops plus the output flop
	AST_ON_CAUSE: assert property (($rose(termOn) && (asyncMode || transition))
		|-> $past(odtPin, 3))
		else $error("termination on without odt");
	// sync turn-on may land after odt dropped, but never long after
	AST_ON_RECENT: assert property ($rose(termOn) |-> odtAge < 9'h100)
		else $error("termination on long after odt dropped");
	AST_WR_DYN: assert property (rttWrSel |-> dynEnable)
		else $error("write strength while dynamic off");
	AST_WR_CODE: assert property ($rose(rttWrSel) |-> !rttCode[2] && rttCode != 3'h0)
		else $error("bad write strength code");
	AST_WR_MIN: assert property ($rose(rttWrSel) |-> rttWrSel[*8])
		else $error("write strength too short");
	AST_ASY_ENTRY: assert property ($rose(asyncMode) |-> $past(transition) && !ckePin)
		else $error("async without transition");
	AST_TR_START: assert property ($rose(transition) |-> allBanksIdle && !$past(ckePin, 2))
		else $error("transition without cke low");
	AST_TR_LEN: assert property ($rose(transition) |-> transition[*6])
		else $error("transition too short");
endmodule // dram_odt_ctrl_sva

//--- bench/ddr_ctrl_model.sv
`timescale 1ns/1ps
module ddr_ctrl_model (
	input wire logic sys_clk, // bench clock
	output logic ckPin, // link clock
	output logic odtPin, // odt
	output logic ckePin, // cke
	output logic [3:0] cmdN, // cs ras cas we
	output logic [2:0] bankAddr, // bank
	output logic [15:0] addrPin // address
);
	initial
	begin
		{odtPin, ckePin, cmdN, bankAddr, addrPin} = {2'b01, 4'hF, 3'h0, 16'h0000};
		ckPin = 1'b0;
		#37;
		forever #400 ckPin = ~ckPin; // free running, power-down needs a live clock
	end
	task automatic cyc(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
		input logic odt, input logic cke);
		@(negedge ckPin);
		@(posedge sys_clk);
		#5;
		odtPin = odt;
		ckePin = cke;
		cmdN = c;
		bankAddr = b;
		addrPin = (c == 4'hF) ? ~addrPin : a; // no stale address while deselected
	endtask
endmodule // ddr_ctrl_model

//--- bench/tb_dram_odt_ctrl.sv
`timescale 1ns/1ps
`include "odt_ctrl_map.svh"
module tb_dram_odt_ctrl;
	logic sys_clk, reset, ckPin, odtPin, ckePin, allBanksIdle, termOn, rttWrSel;
	logic dynEnable, asyncMode, transition, odt, cke;
	logic [3:0] cmdN;
	logic [2:0] bankAddr, nom;
	logic [1:0] wr;
	logic [15:0] addrPin;
	logic [4:0] wl;
	logic [31:0] seed = 32'h0000_0021;
	odt_ctrl_pkg::rttCode_t rttCode;
	int failures = 0;
	int n_tests = 0;
	wire logic [2:0] sel = {asyncMode, rttWrSel, termOn};
	ddr_ctrl_model i_ddr_ctrl_model (.sys_clk(sys_clk), .ckPin(ckPin), .odtPin(odtPin),
		.ckePin(ckePin), .cmdN(cmdN), .bankAddr(bankAddr), .addrPin(addrPin));
	dram_odt_ctrl i_dram_odt_ctrl (.sys_clk(sys_clk), .reset(reset), .ckPin(ckPin),
		.odtPin(odtPin), .ckePin(ckePin), .csN(cmdN[3]), .rasN(cmdN[2]), .casN(cmdN[1]),
		.weN(cmdN[0]), .bankAddr(bankAddr), .addrPin(addrPin), .writeLatency(wl),
		.allBanksIdle(allBanksIdle), .termOn(termOn), .rttCode(rttCode), .rttWrSel(rttWrSel),
		.dynEnable(dynEnable), .asyncMode(asyncMode), .transition(transition));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// dll freezes in power-down only with A12 clear and all banks idle
	function automatic logic pdFrozen(input int a);
		return (a == 0) || (a == 2);
	endfunction
	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) i_ddr_ctrl_model.cyc(4'hF, 3'h0, 16'h0000, odt, cke);
	endtask
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
		i_ddr_ctrl_model.cyc(c, b, a, odt, cke);
	endtask
	// exact link-cycle latency: old value one cycle before, new value at the point
	task automatic lat(input int n, input int s, input logic e);
		idle(n - 1);
		chk({2'h0, sel[s]}, {2'h0, !e});
		idle(1);
		chk({2'h0, sel[s]}, {2'h0, e});
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		failures++;
		results();
	end
	initial
	begin
		reset = 1'b1;
		allBanksIdle = 1'b1;
		odt = 1'b0;
		cke = 1'b1;
		wl = 5'(5 + rnd() % 4);
		repeat (12) @(posedge sys_clk);
		#5 reset = 1'b0;
		for (int t = 0; t < 3; t++)
		begin
			nom = 3'(rnd() % 7 + 1);
			wr = 2'(rnd() % 3 + 1);
			cmd(`CMD_MRS, `MR1_SEL, {6'h00, nom[2], 2'h0, nom[1], 3'h0, nom[0], 2'h0});
			cmd(`CMD_MRS, `MR2_SEL, {5'h00, wr, 9'h000});
			cmd(`CMD_MRS, `MR0_SEL, 16'h0001);
			idle(2);
			chk({2'h0, dynEnable}, 3'h1);
			odt = 1'b1;
			idle(1);
			lat(wl, 0, 1'b1);
			chk(rttCode, nom);
			for (int b = 0; b < 2; b++)
			begin
				cmd(`CMD_WRITE, 3'(rnd()), {3'h0, 1'(b), 12'(rnd())});
				lat(wl, 1, 1'b1);
				chk(rttCode, {1'b0, wr});
				lat(b ? 6 : 4, 1, 1'b0);
				chk(rttCode, nom);
			end
			odt = 1'b0;
			idle(1);
			lat(wl, 0, 1'b0);
			cmd(`CMD_MRS, `MR2_SEL, 16'h0000);
			idle(2);
			chk({2'h0, dynEnable}, 3'h0);
			odt = 1'b1;
			cmd(`CMD_WRITE, 3'h0, 16'h1000);
			idle(wl + 1);
			chk({2'h0, rttWrSel}, 3'h0);
			odt = 1'b0;
			idle(wl + 2);
			for (int a = 0; a < 4; a++)
			begin
				allBanksIdle = (a != 3);
				cmd(`CMD_MRS, `MR0_SEL, {3'h0, 1'(a == 1), 12'h001});
				if (a == 2)
					cmd(`CMD_REFRESH, 3'h0, 16'h0000);
				cke = 1'b0;
				idle(2);
				chk({2'h0, transition}, {2'h0, pdFrozen(a)});
				idle(2);
				chk({2'h0, asyncMode}, {2'h0, a == 0});
				chk({2'h0, transition}, {2'h0, a == 2});
				odt = 1'b1;
				idle(1);
				repeat (4) @(posedge sys_clk);
				#5;
				chk({2'h0, termOn}, {2'h0, pdFrozen(a)});
				idle(4);
				odt = 1'b0;
				idle(wl + 1);
				chk({2'h0, termOn}, 3'h0);
				cke = 1'b1;
				idle(3);
				chk({2'h0, asyncMode}, 3'h0);
			end
			$display("round %0d done", t);
		end
		results();
	end
endmodule // tb_dram_odt_ctrl
bind dram_odt_ctrl dram_odt_ctrl_sva i_dram_odt_ctrl_sva (.sys_clk, .reset, .odtPin, .ckePin,
	.allBanksIdle, .termOn, .rttCode, .rttWrSel, .dynEnable, .asyncMode, .transition);
